/* File: verilog/clkgen_ctrl_bytes.sv */
`include "clkgen_ctrl_consts.svh"
// Control byte bank with request-driven reference pair gating.
module clkgen_ctrl_bytes
  import clkgen_ctrl_pkg::*;
(
  input  wire logic                  SYS_CLK_IN,        // 125 MHz clock.
  input  wire logic                  NRST_IN,           // Synchronous reset, active low.
  input  wire logic                  REG_WR_IN,         // Byte write strobe.
  input  wire logic                  REG_RD_IN,         // Byte read strobe.
  input  wire logic [7:0]            REG_ADDR_IN,       // Byte offset.
  input  wire logic [7:0]            REG_WDATA_IN,      // Write data.
  input  wire logic                  SERIAL_REF_COMPLEMENT_IN, // Reference complement clock.
  input  wire logic [8:0]            OUTPUT_REQUEST_N_IN,      // Request pins 9..1, low = request.
  input  wire logic                  BUS_CLOCK_HALT_N_IN,      // Software halt, active low.
  output logic      [7:0]            REG_RDATA_OUT,     // Read data.
  output logic                       REG_RVALID_OUT,    // Read data valid pulse.
  output ctrl_fields_t               CTRL_OUT,          // Decoded controls.
  output logic      [8:0]            PAIR_RUN_OUT,      // Pair 9..1 clock running.
  output logic      [8:0]            PAIR_DRIVE_EN_OUT  // Pair 9..1 driven.
);
  logic [7:0] drive_a_q;
  logic [7:0] spread_q;
  logic [7:0] ref_pair_q;
  logic [7:0] video_drive_q;
  logic [7:0] req_en_hi_q;
  logic [7:0] req_speed_q;
  logic [8:0] req_n_acc;
  logic [8:0] halt_eligible;
  logic       ref_s1_q;
  logic       ref_s2_q;
  logic       ref_s3_q;
  logic       ref_rise;
  logic       halt_s1_q;
  logic       halt_s2_q;
  reg_access_t acc;

  assign acc = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN, wdata: REG_WDATA_IN};

  // Register writes; the identity byte ignores writes.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      drive_a_q     <= `RST_DRIVE_A;
      spread_q      <= `RST_SPREAD_VIDEO;
      ref_pair_q    <= `RST_REF_PAIR;
      video_drive_q <= `RST_VIDEO_DRIVE;
      req_en_hi_q   <= `RST_REQ_EN_HI;
      req_speed_q   <= `RST_REQ_SPEED;
    end else if (acc.wr) begin
      case (acc.addr)
        `OFS_DRIVE_A:      drive_a_q     <= acc.wdata;
        `OFS_SPREAD_VIDEO: spread_q      <= acc.wdata;
        `OFS_REF_PAIR:     ref_pair_q    <= acc.wdata;
        `OFS_VIDEO_DRIVE:  video_drive_q <= acc.wdata;
        `OFS_REQ_EN_HI:    req_en_hi_q   <= acc.wdata;
        `OFS_REQ_SPEED:    req_speed_q   <= acc.wdata;
        default: ;
      endcase
    end
  end

  // Read path; unmapped offsets return zero.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      REG_RDATA_OUT  <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= acc.rd;
      if (acc.rd) begin
        case (acc.addr)
          `OFS_IDENT:        REG_RDATA_OUT <= `ID_VALUE; // Arbitrary identity value.
          `OFS_DRIVE_A:      REG_RDATA_OUT <= drive_a_q;
          `OFS_SPREAD_VIDEO: REG_RDATA_OUT <= spread_q;
          `OFS_REF_PAIR:     REG_RDATA_OUT <= ref_pair_q;
          `OFS_VIDEO_DRIVE:  REG_RDATA_OUT <= video_drive_q;
          `OFS_REQ_EN_HI:    REG_RDATA_OUT <= req_en_hi_q;
          `OFS_REQ_SPEED:    REG_RDATA_OUT <= req_speed_q;
          default:           REG_RDATA_OUT <= 8'h00;
        endcase
      end
    end
  end

  // Decoded control fields registered onto the output.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      CTRL_OUT <= '0;
    end else begin
      CTRL_OUT.serial_bus_48mhz_drive        <= drive_a_q[`BIT_USB_DRIVE];    // [RQ1]
      CTRL_OUT.free_run_bus_clock_zero_drive <= drive_a_q[`BIT_FREE0_DRIVE];  // [RQ2]
      CTRL_OUT.spread_depth                  <= spread_q[5:4];                // [RQ3]
      CTRL_OUT.video_spread_out_en           <= spread_q[`BIT_SS_OUT_EN];     // [RQ4]
      CTRL_OUT.video_spread_mod_en           <= spread_q[`BIT_SS_MOD_EN];     // [RQ5]
      CTRL_OUT.ref_pair_out_en               <= ref_pair_q[5:4];              // [RQ6]
      CTRL_OUT.ref_pair_halt_eligible        <= ref_pair_q[2:0];              // [RQ7]
      CTRL_OUT.video_drive                   <= video_drive_q[`BIT_VIDEO_DRIVE]; // [RQ8]
      CTRL_OUT.request_enable <= {req_en_hi_q, req_speed_q[`BIT_REQ1_EN]}; // [RQ9] [RQ10]
      CTRL_OUT.panel_speed_100               <= req_speed_q[`BIT_PANEL_SPEED]; // [RQ11]
      CTRL_OUT.bus_clock_drive               <= req_speed_q[3:0];             // [RQ12]
    end
  end

  // Synchronise the reference complement and software halt, then find reference complement rising edges.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      halt_s1_q <= 1'b1;
      halt_s2_q <= 1'b1;
    end else begin
      ref_s1_q  <= SERIAL_REF_COMPLEMENT_IN;
      ref_s2_q  <= ref_s1_q;
      ref_s3_q  <= ref_s2_q;
      halt_s1_q <= BUS_CLOCK_HALT_N_IN;
      halt_s2_q <= halt_s1_q;
    end
  end

  assign ref_rise = ref_s2_q & ~ref_s3_q;

  // One debouncer per request line.
  genvar g;
  generate
    for (g = 0; g < `REQ_LINES; g++) begin : gen_req
      request_debounce u_deb (
        .sys_clk_in   (SYS_CLK_IN),
        .nrst_in      (NRST_IN),
        .sample_en_in (ref_rise),
        .req_n_in     (OUTPUT_REQUEST_N_IN[g]),
        .req_n_out    (req_n_acc[g])
      );
    end
  endgenerate

  // Pairs 8 and 9 may also be halted by the software halt when eligible.
  assign halt_eligible = {ref_pair_q[1], ref_pair_q[0], 7'h00};

  // Stop a pair at the next reference edge after its enabled request goes high.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      PAIR_RUN_OUT      <= 9'h1ff;
      PAIR_DRIVE_EN_OUT <= 9'h1ff;
    end else if (ref_rise) begin
      for (int i = 0; i < `REQ_LINES; i++) begin
        if ((CTRL_OUT.request_enable[i] && req_n_acc[i]) ||
            (halt_eligible[i] && !halt_s2_q)) begin
          PAIR_RUN_OUT[i]      <= 1'b0; // [RQ14]
          PAIR_DRIVE_EN_OUT[i] <= 1'b0; // [RQ14]
        end else begin
          PAIR_RUN_OUT[i]      <= 1'b1;
          PAIR_DRIVE_EN_OUT[i] <= (i == 7) ? ref_pair_q[4] :
                                  (i == 8) ? ref_pair_q[5] : 1'b1; // [RQ6]
        end
      end
    end
  end
endmodule : clkgen_ctrl_bytes

/* File: verilog/clkgen_ctrl_consts.svh */
// Operation
// RQ1: Byte 8 bit 2 sets 48 MHz serial-bus clock drive, resets high.
// RQ2: Byte 8 bit 0 sets free-running bus clock zero drive, resets high.
// RQ3: Byte 9 bits 5:4 pick spread depth for video and panel, default 00.
// RQ4: Byte 9 bit 2 enables spread video output, else tri-stated; resets enabled.
// RQ5: Byte 9 bit 1 enables spread modulation on video clock; resets enabled.
// RQ6: Byte 10 bits 5,4 enable reference pairs 9,8; resets enabled.
// RQ7: Byte 10 bits 2:0 make pairs 10,9,8 stoppable by software halt; code gates only pairs 9,8, from bits 1,0.
// RQ8: Byte 11 bit 3 sets drive of both video outputs; resets low.
// RQ9: Byte 12 bits 7:0 enable request inputs 9 to 2; reset disabled.
// RQ10: Byte 13 bit 7 enables request input 1; resets disabled.
// RQ11: Byte 13 bit 6 picks panel clock 96 or 100 MHz; resets 100.
// RQ12: Byte 13 bits 3:0 set drive of bus clocks 4 to 1; reset high.
// RQ13: Request input change counts after two stable reference-complement edges.
// RQ14: Enabled request high stops assigned pairs after next transition, low undriven.
// RQ15: Software writes reserved bits with fixed values; identity byte is read-only.
`ifndef CLKGEN_CTRL_CONSTS_SVH
`define CLKGEN_CTRL_CONSTS_SVH
`define OFS_IDENT        8'h07
`define OFS_DRIVE_A      8'h08
`define OFS_SPREAD_VIDEO 8'h09
`define OFS_REF_PAIR     8'h0a
`define OFS_VIDEO_DRIVE  8'h0b
`define OFS_REQ_EN_HI    8'h0c
`define OFS_REQ_SPEED    8'h0d
`define RST_DRIVE_A      8'h07
`define RST_SPREAD_VIDEO 8'h0e
`define RST_REF_PAIR     8'hf0
`define RST_VIDEO_DRIVE  8'h00
`define RST_REQ_EN_HI    8'h00
`define RST_REQ_SPEED    8'h7f
`define ID_VALUE         8'h5a
`define BIT_USB_DRIVE    2
`define BIT_FREE0_DRIVE  0
`define BIT_SS_OUT_EN    2
`define BIT_SS_MOD_EN    1
`define BIT_VIDEO_DRIVE  3
`define BIT_REQ1_EN      7
`define BIT_PANEL_SPEED  6
`define REQ_LINES        9
`define REF_PAIRS        3
`endif

/* File: verilog/clkgen_ctrl_pkg.sv */
package clkgen_ctrl_pkg;
  // Register-facing control fields decoded for the clock core.
  typedef struct packed {
    logic       serial_bus_48mhz_drive;
    logic       free_run_bus_clock_zero_drive;
    logic [1:0] spread_depth;
    logic       video_spread_out_en;
    logic       video_spread_mod_en;
    logic [1:0] ref_pair_out_en;
    logic [2:0] ref_pair_halt_eligible;
    logic       video_drive;
    logic [8:0] request_enable;
    logic       panel_speed_100;
    logic [3:0] bus_clock_drive;
  } ctrl_fields_t;
  // Bus access strobe group.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;
endpackage : clkgen_ctrl_pkg

/* File: verilog/request_debounce.sv */
`include "clkgen_ctrl_consts.svh"
// Synchronises one request line and accepts a level after two stable sampling edges.
module request_debounce (
  input  wire logic sys_clk_in,   // System clock.
  input  wire logic nrst_in,      // Synchronous reset, active low.
  input  wire logic sample_en_in, // Rising edge of reference complement.
  input  wire logic req_n_in,     // Raw asynchronous request pin.
  output logic      req_n_out     // Accepted request level.
);
  logic sync1_q;
  logic sync2_q;
  logic cand_q;
  logic cnt_q;

  // Two flip-flop synchroniser, reset to the running level of the pin.
  // Resetting to the stop level would gate an enabled pair until the debounce settled.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= req_n_in;
      sync2_q <= sync1_q;
    end
  end

  // Level must be seen on three consecutive sampling edges to be accepted.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cand_q    <= 1'b0;
      cnt_q     <= 1'b0;
      req_n_out <= 1'b0;
    end else if (sample_en_in) begin
      if (sync2_q != cand_q) begin
        cand_q <= sync2_q;
        cnt_q  <= 1'b0;
      end else if (!cnt_q) begin
        cnt_q <= 1'b1;
      end else begin
        req_n_out <= cand_q; // [RQ13]
      end
    end
  end
endmodule : request_debounce

/* File: tb/clkgen_ctrl_bytes_asserts.sv */
`include "clkgen_ctrl_consts.svh"
// Watches the byte bank ports for read, write and output gating relations.
module clkgen_ctrl_bytes_asserts
  import clkgen_ctrl_pkg::*;
(
  input wire logic         SYS_CLK_IN,       // System clock.
  input wire logic         NRST_IN,          // Reset, active low.
  input wire logic         REG_WR_IN,        // Write strobe.
  input wire logic         REG_RD_IN,        // Read strobe.
  input wire logic [7:0]   REG_ADDR_IN,      // Byte offset.
  input wire logic [7:0]   REG_WDATA_IN,     // Write data.
  input wire logic [7:0]   REG_RDATA_OUT,    // Read data.
  input wire logic         REG_RVALID_OUT,   // Read valid.
  input wire ctrl_fields_t CTRL_OUT,         // Decoded controls.
  input wire logic [8:0]   PAIR_RUN_OUT,     // Pair running.
  input wire logic [8:0]   PAIR_DRIVE_EN_OUT // Pair driven.
);
  logic [7:0] wd1_q, wd2_q;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Delays write data so it lines up with the field update two edges later.
  always_ff @(posedge SYS_CLK_IN) begin
    wd1_q <= REG_WDATA_IN;
    wd2_q <= wd1_q;
  end
  chk_read_valid: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read strobe without valid pulse");
  chk_ident_read: assert property (REG_RD_IN && REG_ADDR_IN == 8'h07 |=>
    REG_RDATA_OUT == `ID_VALUE) else $error("identity byte read wrong");
  chk_ctrl_hold: assert property ((!REG_WR_IN || REG_ADDR_IN == 8'h07) |=> ##1
    $stable(CTRL_OUT)) else $error("controls moved without a write");
  chk_drive_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h08 |=> ##1
    {CTRL_OUT.serial_bus_48mhz_drive, CTRL_OUT.free_run_bus_clock_zero_drive}
    == {wd2_q[2], wd2_q[0]}) else $error("drive byte fields wrong");
  chk_spread_ctl: assert property (REG_WR_IN && REG_ADDR_IN == 8'h09 |=> ##1
    {CTRL_OUT.spread_depth, CTRL_OUT.video_spread_out_en, CTRL_OUT.video_spread_mod_en}
    == {wd2_q[5:4], wd2_q[2:1]}) else $error("spread byte fields wrong");
  chk_ref_pair: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0a |=> ##1
    {CTRL_OUT.ref_pair_out_en, CTRL_OUT.ref_pair_halt_eligible} == {wd2_q[5:4], wd2_q[2:0]})
    else $error("pair byte fields wrong");
  chk_video_drive: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0b |=> ##1
    CTRL_OUT.video_drive == wd2_q[3]) else $error("video drive field wrong");
  chk_req_high: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0c |=> ##1
    CTRL_OUT.request_enable[8:1] == wd2_q) else $error("request enables wrong");
  chk_speed_drive: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0d |=> ##1
    {CTRL_OUT.request_enable[0], CTRL_OUT.panel_speed_100, CTRL_OUT.bus_clock_drive}
    == {wd2_q[7:6], wd2_q[3:0]}) else $error("speed byte fields wrong");
  chk_stop_undriven: assert property ((~PAIR_RUN_OUT & PAIR_DRIVE_EN_OUT) == 9'h000)
    else $error("stopped pair still driven");
endmodule : clkgen_ctrl_bytes_asserts
bind clkgen_ctrl_bytes clkgen_ctrl_bytes_asserts u_chk (.SYS_CLK_IN(SYS_CLK_IN),
  .NRST_IN(NRST_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .CTRL_OUT(CTRL_OUT), .PAIR_RUN_OUT(PAIR_RUN_OUT), .PAIR_DRIVE_EN_OUT(PAIR_DRIVE_EN_OUT));

/* File: tb/clkgen_ctrl_bytes_tb.sv */
`include "clkgen_ctrl_consts.svh"
// Drives the byte bank through its strobes and request pins and checks the results.
module clkgen_ctrl_bytes_tb
  import clkgen_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rst_n, wr, rd, refc, halt_n, rvalid;
  logic [7:0]   addr, wdata, rdata;
  logic [8:0]   req, run, drv;
  ctrl_fields_t ctrl;
  int           bad_count, samples_checked, cycles;
  logic [7:0]   rst_v [0:7] = '{`ID_VALUE, 8'h07, 8'h0e, 8'hf0, 8'h00, 8'h00, 8'h7f, 8'h00};
  logic [7:0]   wr_v [0:7] = '{8'h00, 8'he1, 8'hd2, 8'hc3, 8'hb4, 8'ha5, 8'h96, 8'hff};
  clkgen_ctrl_bytes u_dut (.SYS_CLK_IN(clk), .NRST_IN(rst_n), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .SERIAL_REF_COMPLEMENT_IN(refc),
    .OUTPUT_REQUEST_N_IN(req), .BUS_CLOCK_HALT_N_IN(halt_n), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .CTRL_OUT(ctrl), .PAIR_RUN_OUT(run), .PAIR_DRIVE_EN_OUT(drv));
  // Maps bytes 8 to 13 onto the decoded control fields.
  function automatic logic [25:0] fields(logic [7:0] b [0:7]);
    return {b[1][2], b[1][0], b[2][5:4], b[2][2:1], b[3][5:4], b[3][2:0], b[4][3], b[5],
            b[6][7:6], b[6][3:0]};
  endfunction : fields
  // Compares one value and counts the result.
  task automatic chk(string n, logic [25:0] e, logic [25:0] g);
    samples_checked++;
    if (e !== g) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Writes one byte, then waits until the controls have followed.
  task automatic wr_b(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    #1 wr = 1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr_b
  // Reads one byte and checks the valid pulse and data one cycle later.
  task automatic rd_b(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    #1 rd = 1;
    addr = a;
    @(posedge clk);
    #1 rd = 0;
    chk("read valid", 1, rvalid);
    chk("read data", e, rdata);
  endtask : rd_b
  // Runs the reference complement clock for n periods of 16 cycles.
  task automatic ref_cyc(int n);
    repeat (n) begin
      repeat (8) @(posedge clk);
      #1 refc = 1;
      repeat (8) @(posedge clk);
      #1 refc = 0;
    end
  endtask : ref_cyc
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // Makes the 125 MHz clock.
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Main sequence of register and request scenarios.
  initial begin
    {rst_n, wr, rd, refc, addr, wdata, req} = '0;
    halt_n = 1;
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    @(posedge clk);
    #1;
    chk("reset controls", fields(rst_v), ctrl);
    for (int i = 0; i < 8; i++) begin
      rd_b(8'h07 + i[7:0], rst_v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr_b(8'h07 + i[7:0], wr_v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      rd_b(8'h07 + i[7:0], (i == 0) ? `ID_VALUE : (i == 7) ? 8'h00 : wr_v[i]);
    end
    chk("written controls", fields(wr_v), ctrl);
    for (int c = 0; c < 4; c++) begin
      wr_b(8'h09, {2'b00, c[1:0], 4'he});
      chk("spread depth", c[1:0], ctrl.spread_depth);
    end
    req[0] = 1;
    ref_cyc(1);
    req[0] = 0;
    ref_cyc(3);
    chk("glitch run", 3'b111, run[2:0]);
    chk("disabled pair drive", 2'b00, drv[8:7]);
    req = 9'h005;
    ref_cyc(4);
    chk("request run", 3'b110, run[2:0]);
    chk("request drive", 3'b110, drv[2:0]);
    halt_n = 0;
    ref_cyc(4);
    chk("halt run", 3'b001, {run[8:7], run[1]});
    halt_n = 1;
    req = 9'h000;
    ref_cyc(4);
    chk("resumed run", 9'h1ff, run);
    wr_b(8'h0a, 8'hf0);
    ref_cyc(2);
    chk("enabled pair drive", 9'h1ff, drv);
    report_and_stop();
  end
endmodule : clkgen_ctrl_bytes_tb
